// ==== hw/tdm_pkg.sv ====
// Shared constants for the time-multiplexed serial bus and its two ends
package tdm_pkg;
  // ==========================================
  // Register offsets on the processor side
  localparam logic [7:0] OFS_RECEIVE = 8'h30;
  localparam logic [7:0] OFS_TRANSMIT = 8'h31;
  localparam logic [7:0] OFS_CONTROL = 8'h32;
  localparam logic [7:0] OFS_SLOT_EN = 8'h33;
  localparam logic [7:0] OFS_ADDR_CFG = 8'h34;
  localparam logic [7:0] OFS_HISTORY = 8'h35;
  // ==========================================
  // Control and status field positions
  localparam int B_MODE = 0;
  localparam int B_WLEN = 1;
  localparam int B_LOOP = 2;
  localparam int B_FSM = 3;
  localparam int B_CLK_SRC = 4;
  localparam int B_FRM_SRC = 5;
  localparam int B_XRST = 6;
  localparam int B_RRST = 7;
  localparam int B_RRDY = 10;
  localparam int B_XRDY = 11;
  // Writable control bits: free, soft, rrst, xrst, frame src, clock src, fsm, mode
  localparam logic [15:0] CTRL_WMASK = 16'hc0f9;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // ==========================================
  // Frame and slot timing, counted in bus clocks
  localparam logic [6:0] FRAME_START = 7'h00;
  localparam logic [6:0] FRAME_LAST = 7'h7f;
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] ADDR_LAST = 4'h7;
  localparam logic [3:0] SLOT_LAST = 4'hf;
  localparam logic [2:0] SLOT_STEP = 3'h1;
  // Bus clock is the processor clock divided by four
  localparam logic [1:0] DIV_STEP = 2'h1;
  // Word carried from register side to link side
  localparam int BUNDLE_W = 45;
endpackage

// ==== hw/tdm_bus_if.sv ====
// Four-wire shared bus joining the device end and the peer end
interface tdm_bus_if;
  // Bench-made clock and frame, used while neither end drives them
  logic tb_bit_clock;
  logic tb_frame_pulse;
  // Device end drivers, enables active low
  logic dev_clk_o, dev_clk_oe_n, dev_frm_o, dev_frm_oe_n;
  logic dev_dat_o, dev_dat_oe_n, dev_add_o, dev_add_oe_n;
  // Peer end drivers, enables active low
  logic peer_clk_o, peer_clk_oe_n, peer_frm_o, peer_frm_oe_n;
  logic peer_dat_o, peer_dat_oe_n, peer_add_o, peer_add_oe_n;
  // Resolved wire levels; undriven data and address read low as if pulled down
  logic bus_bit_clock;
  logic bus_frame_pulse;
  logic shared_serial_data_line;
  logic slot_address_line;
  assign bus_bit_clock = !dev_clk_oe_n ? dev_clk_o : !peer_clk_oe_n ? peer_clk_o : tb_bit_clock;
  assign bus_frame_pulse = !dev_frm_oe_n ? dev_frm_o :
                           !peer_frm_oe_n ? peer_frm_o : tb_frame_pulse;
  assign shared_serial_data_line = !dev_dat_oe_n ? dev_dat_o :
                                   !peer_dat_oe_n ? peer_dat_o : 1'b0;
  assign slot_address_line = !dev_add_oe_n ? dev_add_o : !peer_add_oe_n ? peer_add_o : 1'b0;
  modport dev (
    input bus_bit_clock, bus_frame_pulse, shared_serial_data_line, slot_address_line,
    output dev_clk_o, dev_clk_oe_n, dev_frm_o, dev_frm_oe_n,
    output dev_dat_o, dev_dat_oe_n, dev_add_o, dev_add_oe_n
  );
  modport peer (
    input bus_bit_clock, bus_frame_pulse, shared_serial_data_line, slot_address_line,
    output peer_clk_o, peer_clk_oe_n, peer_frm_o, peer_frm_oe_n,
    output peer_dat_o, peer_dat_oe_n, peer_add_o, peer_add_oe_n
  );
endinterface

// ==== hw/tdm_port_device.sv ====
// Device end of the time-multiplexed serial bus with its register file
// Contract
// R1: Eight devices share clock, frame, data, address
// R2: One driver per slot, others undriven
// R3: Every device samples data and address always
// R4: Address match moves word, raises receive interrupt
// R5: Control bit 0 selects slot mode
// R6: Loopback and format bits read zero, 16-bit words
// R7: Frame sync mode and error flags ignored
// R8: Control writes apply after slot 7; the clock source bit takes effect at the next processor clock
// R9: Clock source bit drives clock at quarter rate
// R10: Frame source bit drives frame pulse
// R11: At most one clock or frame source
// R12: Slot enable bits select transmit slots
// R13: No two transmitters share a slot
// R14: Slot enable writes apply next frame
// R15: Address config: receive low, transmit high
// R16: Sampled address AND receive address nonzero
// R17: Status shows current slot number
// R18: Status shows last receive slot plus one
// R19: Status shows address sampled mid-slot
// R20: One frame pulse per 128 bus clocks
// R21: Sixteen bits per slot, MSB first, rising edges
// R22: Address LSB first, then driven high
// R23: Unloaded transmit word leaves slot undriven
module tdm_port_device (
  // Processor clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Memory-mapped register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Receive event
  output logic receive_done_interrupt,
  // Shared bus
  tdm_bus_if.dev bus // R1
);
  // ==========================================
  // Register side (ref_clk)
  logic [15:0] ctrl, transmit_holding_word, receive_holding_word;
  logic [7:0] slot_en, own_transmit_address, own_receive_address, last_sampled_address;
  logic [2:0] last_receive_slot_next;
  logic tx_seq, dirty, req, rrdy;
  logic [tdm_pkg::BUNDLE_W-1:0] bundle;
  logic [1:0] ack_s, empty_s, div;
  logic [2:0] rx_s, adr_s;
  logic [2:0] slot_g1, slot_g2;
  logic clk_q, clk_oe_n;
  // Link side (bus_bit_clock)
  logic lrst_s1, lrst;
  logic [6:0] cnt;
  logic req_s1, req_s2, ack, frm_q, frm_oe_n;
  logic [tdm_pkg::BUNDLE_W-1:0] stage;
  logic eff_mode, eff_xrst, eff_rrst, eff_txm;
  logic [7:0] eff_en, eff_ra, ta_l, addr_sh, addr_l;
  logic used_seq, tx_act, dat_q, add_q, match, rx_tgl, adr_tgl;
  logic [15:0] tx_sh, rx_word_l;
  logic [14:0] receive_shift_register;
  logic [2:0] rx_next_l, slot_gray;

  // Register decode
  wire wr_ctrl = reg_wr && reg_addr == tdm_pkg::OFS_CONTROL;
  wire wr_en = reg_wr && reg_addr == tdm_pkg::OFS_SLOT_EN;
  wire wr_acfg = reg_wr && reg_addr == tdm_pkg::OFS_ADDR_CFG;
  wire wr_tx = reg_wr && reg_addr == tdm_pkg::OFS_TRANSMIT;
  wire rd_rx = reg_rd && reg_addr == tdm_pkg::OFS_RECEIVE;
  wire any_wr = wr_ctrl | wr_en | wr_acfg | wr_tx;
  wire launch = dirty & ~req & ~ack_s[1];
  wire rx_evt = rx_s[2] ^ rx_s[1];
  wire adr_evt = adr_s[2] ^ adr_s[1];
  wire xrdy = empty_s[1] & ~dirty & ~req;
  wire [2:0] cur_slot = {slot_g2[2], slot_g2[2] ^ slot_g2[1], ^slot_g2};
  wire [1:0] next_div = div + tdm_pkg::DIV_STEP;
  wire [tdm_pkg::BUNDLE_W-1:0] next_bundle = {ctrl[tdm_pkg::B_MODE], ctrl[tdm_pkg::B_XRST],
    ctrl[tdm_pkg::B_RRST], ctrl[tdm_pkg::B_FRM_SRC], slot_en, own_transmit_address,
    own_receive_address, transmit_holding_word, tx_seq};

  // Read data selection; loopback, format and pin bits read zero
  wire [15:0] ctrl_rd = {ctrl[15:12], xrdy, rrdy, ctrl[9:0] & tdm_pkg::CTRL_WMASK[9:0]}; // R6 R7
  wire [15:0] hist_rd = {2'b00, cur_slot, last_receive_slot_next, last_sampled_address};
  wire [15:0] rd_val =
    reg_addr == tdm_pkg::OFS_RECEIVE ? receive_holding_word :
    reg_addr == tdm_pkg::OFS_TRANSMIT ? transmit_holding_word :
    reg_addr == tdm_pkg::OFS_CONTROL ? ctrl_rd :
    reg_addr == tdm_pkg::OFS_SLOT_EN ? {8'h00, slot_en} :
    reg_addr == tdm_pkg::OFS_ADDR_CFG ? {own_transmit_address, own_receive_address} :
    reg_addr == tdm_pkg::OFS_HISTORY ? hist_rd : tdm_pkg::RESET_WORD;

  // ==========================================
  // Software registers and the word handshake towards the link
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl <= tdm_pkg::RESET_WORD;
      slot_en <= 8'h00;
      {own_transmit_address, own_receive_address} <= tdm_pkg::RESET_WORD;
      transmit_holding_word <= tdm_pkg::RESET_WORD;
      tx_seq <= 1'b0;
      dirty <= 1'b0;
      req <= 1'b0;
      bundle <= '0;
    end else begin
      if (wr_ctrl) ctrl <= reg_wdata & tdm_pkg::CTRL_WMASK; // R5 R6
      if (wr_en) slot_en <= reg_wdata[7:0]; // R12
      if (wr_acfg) {own_transmit_address, own_receive_address} <= reg_wdata; // R15
      if (wr_tx) begin
        transmit_holding_word <= reg_wdata;
        tx_seq <= ~tx_seq;
      end
      dirty <= any_wr | (dirty & ~launch);
      if (launch) begin
        bundle <= next_bundle;
        req <= 1'b1;
      end else if (ack_s[1]) begin
        req <= 1'b0;
      end
    end
  end

  // Status capture from the link, read data and receive flag
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      receive_holding_word <= tdm_pkg::RESET_WORD;
      last_receive_slot_next <= 3'h0;
      last_sampled_address <= 8'h00;
      rrdy <= 1'b0;
      receive_done_interrupt <= 1'b0;
      reg_rdata <= tdm_pkg::RESET_WORD;
    end else begin
      if (rx_evt) begin
        receive_holding_word <= rx_word_l; // R4
        last_receive_slot_next <= rx_next_l; // R18
      end
      if (adr_evt) last_sampled_address <= addr_l; // R19
      rrdy <= rx_evt | (rrdy & ~rd_rx);
      receive_done_interrupt <= rx_evt; // R4
      if (reg_rd) reg_rdata <= rd_val;
    end
  end

  // Synchronisers for link events and levels
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_s <= 2'b00;
      empty_s <= 2'b00;
      rx_s <= 3'h0;
      adr_s <= 3'h0;
      slot_g1 <= 3'h0;
      slot_g2 <= 3'h0;
    end else begin
      ack_s <= {ack_s[0], ack};
      empty_s <= {empty_s[0], used_seq == stage[0]};
      rx_s <= {rx_s[1:0], rx_tgl};
      adr_s <= {adr_s[1:0], adr_tgl};
      slot_g1 <= slot_gray;
      slot_g2 <= slot_g1; // R17
    end
  end

  // Bus clock generator, quarter of the processor clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div <= 2'h0;
      clk_q <= 1'b0;
      clk_oe_n <= 1'b1;
    end else begin
      div <= next_div;
      clk_q <= ~next_div[1]; // R9
      clk_oe_n <= ~ctrl[tdm_pkg::B_CLK_SRC]; // R9 R11
    end
  end
  assign bus.dev_clk_o = clk_q;
  assign bus.dev_clk_oe_n = clk_oe_n;

  // ==========================================
  // Link side on the bus clock
  wire [6:0] nxt = bus.bus_frame_pulse ? tdm_pkg::FRAME_START : cnt + 7'h01; // R20
  wire frame_start = nxt == tdm_pkg::FRAME_START;
  wire slot_start = nxt[3:0] == tdm_pkg::SLOT_FIRST;
  wire [3:0] bit_no = cnt[3:0];
  wire st_mode = stage[44];
  wire st_xrst = stage[43];
  wire st_rrst = stage[42];
  wire st_txm = stage[41];
  wire [7:0] st_en = stage[40:33];
  wire [7:0] st_ta = stage[32:25];
  wire [7:0] st_ra = stage[24:17];
  wire [15:0] st_tx = stage[16:1];
  wire tx_full = stage[0] != used_seq;
  wire n_mode = frame_start ? st_mode : eff_mode;
  wire n_xrst = frame_start ? st_xrst : eff_xrst;
  wire n_txm = frame_start ? st_txm : eff_txm;
  wire [7:0] n_en = frame_start ? st_en : eff_en;
  wire go = n_mode & n_xrst & n_en[nxt[6:4]] & tx_full; // R12 R23
  wire [7:0] addr_full = {bus.slot_address_line, addr_sh[6:0]};

  // Reset brought into the link domain
  always_ff @(posedge bus.bus_bit_clock) begin
    lrst_s1 <= srst;
    lrst <= lrst_s1;
  end

  // Frame counter, register handshake and frame-boundary settings
  always_ff @(posedge bus.bus_bit_clock) begin
    if (lrst) begin
      cnt <= tdm_pkg::FRAME_LAST;
      {req_s1, req_s2, ack} <= 3'b000;
      stage <= '0;
      {eff_mode, eff_xrst, eff_rrst, eff_txm} <= 4'h0;
      eff_en <= 8'h00;
      eff_ra <= 8'h00;
      frm_q <= 1'b0;
      frm_oe_n <= 1'b1;
      slot_gray <= 3'h0;
    end else begin
      cnt <= nxt;
      req_s1 <= req;
      req_s2 <= req_s1;
      if (req_s2 & ~ack) begin
        stage <= bundle;
        ack <= 1'b1;
      end else if (~req_s2) begin
        ack <= 1'b0;
      end
      if (frame_start) begin
        {eff_mode, eff_xrst, eff_rrst, eff_txm} <= {st_mode, st_xrst, st_rrst, st_txm}; // R8
        eff_en <= st_en; // R14
        eff_ra <= st_ra;
      end
      frm_q <= nxt == tdm_pkg::FRAME_LAST; // R20
      frm_oe_n <= ~(n_mode & n_txm); // R10
      slot_gray <= nxt[6:4] ^ {1'b0, nxt[6:5]};
    end
  end
  assign bus.dev_frm_o = frm_q;
  assign bus.dev_frm_oe_n = frm_oe_n;

  // Transmitter: word MSB first, address LSB first then high
  always_ff @(posedge bus.bus_bit_clock) begin
    if (lrst) begin
      used_seq <= 1'b0;
      tx_act <= 1'b0;
      tx_sh <= tdm_pkg::RESET_WORD;
      ta_l <= 8'h00;
      dat_q <= 1'b0;
      add_q <= 1'b0;
    end else if (slot_start) begin
      tx_act <= go; // R2 R23
      if (go) begin
        used_seq <= stage[0];
        tx_sh <= st_tx;
        ta_l <= st_ta; // R15
        dat_q <= st_tx[15]; // R21
        add_q <= st_ta[0]; // R22
      end
    end else if (tx_act) begin
      tx_sh <= {tx_sh[14:0], 1'b0};
      dat_q <= tx_sh[14]; // R21
      add_q <= nxt[3] ? 1'b1 : ta_l[nxt[2:0]]; // R22
    end
  end
  assign bus.dev_dat_o = dat_q;
  assign bus.dev_add_o = add_q;
  assign bus.dev_dat_oe_n = ~tx_act; // R2
  assign bus.dev_add_oe_n = ~tx_act; // R2

  // Receiver: sample both lines in every slot
  always_ff @(posedge bus.bus_bit_clock) begin
    if (lrst) begin
      receive_shift_register <= 15'h0000;
      addr_sh <= 8'h00;
      addr_l <= 8'h00;
      match <= 1'b0;
      rx_word_l <= tdm_pkg::RESET_WORD;
      rx_next_l <= 3'h0;
      rx_tgl <= 1'b0;
      adr_tgl <= 1'b0;
    end else begin
      receive_shift_register <= {receive_shift_register[13:0], bus.shared_serial_data_line}; // R3
      if (!bit_no[3]) addr_sh[bit_no[2:0]] <= bus.slot_address_line; // R3
      if (bit_no == tdm_pkg::ADDR_LAST) begin
        addr_l <= addr_full; // R19
        adr_tgl <= ~adr_tgl;
        match <= (|(addr_full & eff_ra)) & eff_rrst & eff_mode; // R16
      end
      if (bit_no == tdm_pkg::SLOT_LAST && match) begin
        rx_word_l <= {receive_shift_register, bus.shared_serial_data_line}; // R4
        rx_next_l <= cnt[6:4] + tdm_pkg::SLOT_STEP; // R18
        rx_tgl <= ~rx_tgl;
      end
    end
  end
endmodule

// ==== hw/tdm_port_peer.sv ====
// Peer end of the time-multiplexed serial bus: another processor on the bus
module tdm_port_peer (
  // Processor clock and reset, used for clock generation
  input wire logic ref_clk,
  input wire logic srst,
  // Static role selection
  input wire logic clk_src,
  input wire logic frm_src,
  // Slot configuration, link clock domain
  input wire logic [2:0] tx_slot,
  input wire logic [7:0] tx_addr,
  input wire logic [7:0] rx_addr,
  // Transmit word handshake, link clock domain
  input wire logic [15:0] tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  // Received words, link clock domain
  output logic [15:0] rx_word,
  output logic [2:0] rx_slot,
  output logic rx_valid,
  // Shared bus
  tdm_bus_if.peer bus
);
  logic [1:0] div;
  logic clk_q, clk_oe_n, lrst_s1, lrst, frm_q, pend, tx_act, dat_q, add_q, match;
  logic [6:0] cnt;
  logic [15:0] word, tx_sh;
  logic [14:0] rx_sh;
  logic [7:0] ta_l, addr_sh;

  // ==========================================
  // Bus clock from a divide-by-four of the processor clock
  wire [1:0] next_div = div + tdm_pkg::DIV_STEP;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div <= 2'h0;
      clk_q <= 1'b0;
      clk_oe_n <= 1'b1;
    end else begin
      div <= next_div;
      clk_q <= ~next_div[1]; // R9
      clk_oe_n <= ~clk_src; // R11
    end
  end
  assign bus.peer_clk_o = clk_q;
  assign bus.peer_clk_oe_n = clk_oe_n;

  // ==========================================
  // Link side on the bus clock
  wire [6:0] nxt = bus.bus_frame_pulse ? tdm_pkg::FRAME_START : cnt + 7'h01; // R20
  wire slot_start = nxt[3:0] == tdm_pkg::SLOT_FIRST;
  wire go = pend && nxt[6:4] == tx_slot; // R13
  wire [7:0] addr_full = {bus.slot_address_line, addr_sh[6:0]};
  assign tx_ready = ~pend;

  // Reset brought into the link domain
  always_ff @(posedge bus.bus_bit_clock) begin
    lrst_s1 <= srst;
    lrst <= lrst_s1;
  end

  // Counter, frame pulse and transmitter
  always_ff @(posedge bus.bus_bit_clock) begin
    if (lrst) begin
      cnt <= tdm_pkg::FRAME_LAST;
      frm_q <= 1'b0;
      pend <= 1'b0;
      word <= tdm_pkg::RESET_WORD;
      tx_act <= 1'b0;
      tx_sh <= tdm_pkg::RESET_WORD;
      ta_l <= 8'h00;
      dat_q <= 1'b0;
      add_q <= 1'b0;
    end else begin
      cnt <= nxt;
      frm_q <= nxt == tdm_pkg::FRAME_LAST; // R20
      if (tx_valid && !pend) begin
        word <= tx_word;
        pend <= 1'b1;
      end
      if (slot_start) begin
        tx_act <= go; // R2
        if (go) begin
          pend <= 1'b0;
          tx_sh <= word;
          ta_l <= tx_addr;
          dat_q <= word[15]; // R21
          add_q <= tx_addr[0]; // R22
        end
      end else if (tx_act) begin
        tx_sh <= {tx_sh[14:0], 1'b0};
        dat_q <= tx_sh[14]; // R21
        add_q <= nxt[3] ? 1'b1 : ta_l[nxt[2:0]]; // R22
      end
    end
  end
  assign bus.peer_frm_o = frm_q;
  assign bus.peer_frm_oe_n = ~frm_src; // R11
  assign bus.peer_dat_o = dat_q;
  assign bus.peer_add_o = add_q;
  assign bus.peer_dat_oe_n = ~tx_act; // R2
  assign bus.peer_add_oe_n = ~tx_act; // R2

  // Receiver with address match
  always_ff @(posedge bus.bus_bit_clock) begin
    if (lrst) begin
      rx_sh <= 15'h0000;
      addr_sh <= 8'h00;
      match <= 1'b0;
      rx_word <= tdm_pkg::RESET_WORD;
      rx_slot <= 3'h0;
      rx_valid <= 1'b0;
    end else begin
      rx_sh <= {rx_sh[13:0], bus.shared_serial_data_line}; // R3
      if (!cnt[3]) addr_sh[cnt[2:0]] <= bus.slot_address_line;
      if (cnt[3:0] == tdm_pkg::ADDR_LAST) match <= |(addr_full & rx_addr); // R16
      rx_valid <= cnt[3:0] == tdm_pkg::SLOT_LAST && match;
      if (cnt[3:0] == tdm_pkg::SLOT_LAST && match) begin
        rx_word <= {rx_sh, bus.shared_serial_data_line};
        rx_slot <= cnt[6:4];
      end
    end
  end
endmodule

// ==== tb/tdm_bus_assertions.sv ====
// Checker for the shared four-wire slot bus
module tdm_bus_assertions (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Resolved bus wires
  input wire logic bus_bit_clock,
  input wire logic bus_frame_pulse,
  // Device end drivers
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe_n,
  input wire logic dev_frm_oe_n,
  input wire logic dev_dat_oe_n,
  input wire logic dev_add_o,
  input wire logic dev_add_oe_n,
  // Peer end drivers
  input wire logic peer_clk_oe_n,
  input wire logic peer_frm_oe_n,
  input wire logic peer_dat_oe_n,
  input wire logic peer_add_o,
  input wire logic peer_add_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Bit position in the frame, realigned by each frame pulse
  logic [6:0] pos;
  logic seen;
  always_ff @(posedge bus_bit_clock) begin
    if (srst) begin
      pos <= 7'h00;
      seen <= 1'b0;
    end else begin
      pos <= bus_frame_pulse ? 7'h00 : pos + 7'h01;
      seen <= seen | bus_frame_pulse;
    end
  end
  // ==========================================
  // Wire ownership and framing
  property p_one_driver;
    @(posedge bus_bit_clock) disable iff (srst)
      !(!dev_dat_oe_n && !peer_dat_oe_n) && !(!dev_add_oe_n && !peer_add_oe_n);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("two ends drive data or address");
  property p_frame_period;
    @(posedge bus_bit_clock) disable iff (srst)
      seen |-> (bus_frame_pulse == (pos == 7'h7f));
  endproperty
  a_frame_period: assert property (p_frame_period)
    else $error("frame pulse not once per 128 bus clocks");
  property p_dev_addr_high;
    @(posedge bus_bit_clock) disable iff (srst)
      seen && !dev_add_oe_n && pos[3] |-> dev_add_o;
  endproperty
  a_dev_addr_high: assert property (p_dev_addr_high)
    else $error("device address line low in second half of slot");
  property p_peer_addr_high;
    @(posedge bus_bit_clock) disable iff (srst)
      seen && !peer_add_oe_n && pos[3] |-> peer_add_o;
  endproperty
  a_peer_addr_high: assert property (p_peer_addr_high)
    else $error("peer address line low in second half of slot");
  property p_dev_slot_edge;
    @(posedge bus_bit_clock) disable iff (srst)
      seen && $changed(dev_dat_oe_n) |-> pos[3:0] == 4'h0;
  endproperty
  a_dev_slot_edge: assert property (p_dev_slot_edge)
    else $error("device data enable moved inside a slot");
  property p_dat_add_together;
    @(posedge bus_bit_clock) disable iff (srst)
      dev_dat_oe_n == dev_add_oe_n;
  endproperty
  a_dat_add_together: assert property (p_dat_add_together)
    else $error("device data and address enables differ");
  property p_peer_slot_edge;
    @(posedge bus_bit_clock) disable iff (srst)
      seen && $changed(peer_dat_oe_n) |-> pos[3:0] == 4'h0;
  endproperty
  a_peer_slot_edge: assert property (p_peer_slot_edge)
    else $error("peer data enable moved inside a slot");
  // ==========================================
  // Bus clock made by the device: two ref cycles high, two low
  sequence s_clk_high;
    dev_clk_o [*2];
  endsequence
  sequence s_clk_low;
    !dev_clk_o [*2];
  endsequence
  property p_clk_quarter;
    @(posedge ref_clk) disable iff (srst)
      !dev_clk_oe_n && $rose(dev_clk_o) |-> s_clk_high ##1 s_clk_low ##1 dev_clk_o;
  endproperty
  a_clk_quarter: assert property (p_clk_quarter)
    else $error("device bus clock not a quarter of ref clock");
  property p_single_source;
    @(posedge ref_clk) disable iff (srst)
      !(!dev_clk_oe_n && !peer_clk_oe_n) && !(!dev_frm_oe_n && !peer_frm_oe_n);
  endproperty
  a_single_source: assert property (p_single_source)
    else $error("two sources of bus clock or frame");
endmodule

// ==== tb/tdm_multiprocessor_serial_port_tb.sv ====
// Self-checking bench: device end and peer end joined on the slot bus
module tdm_multiprocessor_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Stimulus, observed outputs and bookkeeping
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic receive_done_interrupt;
  logic [2:0] tx_slot = 3'h0;
  logic [7:0] tx_addr = 8'h00;
  logic [7:0] rx_addr = 8'h04;
  logic [15:0] tx_word = 16'h0000;
  logic tx_valid = 1'b0;
  logic tx_ready;
  logic [15:0] rx_word;
  logic [2:0] rx_slot;
  logic rx_valid;
  logic rd_pend = 1'b0;
  logic [31:0] note;
  logic [18:0] pnote;
  logic [15:0] w;
  logic [31:0] reg_q[$];
  logic [18:0] peer_q[$];
  int fail_count = 0;
  int tests_run = 0;
  int irq_count = 0;
  int cycles = 0;
  int frame_n = 164;
  tdm_bus_if bus ();
  tdm_port_device u_tdm_port_device (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .receive_done_interrupt, .bus(bus.dev));
  tdm_port_peer u_tdm_port_peer (.ref_clk, .srst, .clk_src(1'b0), .frm_src(1'b0), .tx_slot,
    .tx_addr, .rx_addr, .tx_word, .tx_valid, .tx_ready, .rx_word, .rx_slot, .rx_valid,
    .bus(bus.peer));
  tdm_bus_assertions u_tdm_bus_assertions (.ref_clk, .srst,
    .bus_bit_clock(bus.bus_bit_clock), .bus_frame_pulse(bus.bus_frame_pulse),
    .dev_clk_o(bus.dev_clk_o), .dev_clk_oe_n(bus.dev_clk_oe_n),
    .dev_frm_oe_n(bus.dev_frm_oe_n), .dev_dat_oe_n(bus.dev_dat_oe_n),
    .dev_add_o(bus.dev_add_o), .dev_add_oe_n(bus.dev_add_oe_n),
    .peer_clk_oe_n(bus.peer_clk_oe_n), .peer_frm_oe_n(bus.peer_frm_oe_n),
    .peer_dat_oe_n(bus.peer_dat_oe_n), .peer_add_o(bus.peer_add_o),
    .peer_add_oe_n(bus.peer_add_oe_n));
  // ==========================================
  // Clocks: 40 MHz processor clock, 32 ns bench bus clock
  always #12.5 ref_clk = !ref_clk;
  logic bit_clk_tb = 1'b0;
  always #16 bit_clk_tb = !bit_clk_tb;
  assign bus.tb_bit_clock = bit_clk_tb;
  // ==========================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic done(input string t);
    $display("test %s finished, mismatches %0d", t, fail_count);
  endtask
  // Register access: strobe for one cycle, launched at the falling edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    reg_q.push_back({m, e & m});
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
  endtask
  // Peer word offer, held until taken at a bus clock edge
  task automatic send(input logic [15:0] d);
    @(negedge bus.bus_bit_clock);
    tx_word = d;
    tx_valid = 1'b1;
    @(posedge bus.bus_bit_clock);
    for (int i = 0; i < 64 && tx_ready !== 1'b1; i++) @(posedge bus.bus_bit_clock);
    @(negedge bus.bus_bit_clock);
    tx_valid = 1'b0;
    chk("peer tx_ready after offer", 32'h0000_0000, 32'(tx_ready));
  endtask
  task automatic wait_peer();
    for (int i = 0; i < 4 * frame_n && peer_q.size() != 0; i++) @(negedge ref_clk);
    chk("peer notes left", 32'h0000_0000, 32'(peer_q.size()));
  endtask
  task automatic wait_irq(input int n);
    for (int i = 0; i < 4 * frame_n && irq_count < n; i++) @(negedge ref_clk);
    chk("receive interrupts", 32'(n), 32'(irq_count));
  endtask
  // ==========================================
  // Result watchers: read data and interrupts, then peer receptions
  always @(posedge ref_clk) begin
    cycles++;
    if (receive_done_interrupt === 1'b1) irq_count++;
    if (rd_pend) begin
      note = reg_q.pop_front();
      chk("reg_rdata", {16'h0000, note[15:0]}, {16'h0000, reg_rdata & note[31:16]});
    end
    rd_pend <= reg_rd;
    if (cycles == 40000) begin
      fail_count++;
      end_sim();
    end
  end
  always @(posedge bus.bus_bit_clock) begin
    if (rx_valid === 1'b1) begin
      pnote = (peer_q.size() != 0) ? peer_q.pop_front() : 19'h7_ffff;
      chk("peer rx slot and word", {13'h0000, pnote}, {13'h0000, rx_slot, rx_word});
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h0000_ace3));
    bus.tb_frame_pulse = 1'b0;
    repeat (6) @(negedge ref_clk);
    srst = 1'b0;
    // Register defaults, forced-zero format bits, unmapped address
    rd(tdm_pkg::OFS_CONTROL, 16'h00ff, tdm_pkg::RESET_WORD);
    rd(tdm_pkg::OFS_SLOT_EN, 16'h00ff, tdm_pkg::RESET_WORD);
    wr(tdm_pkg::OFS_CONTROL, 16'h00ef);
    rd(tdm_pkg::OFS_CONTROL, 16'h00ff, 16'h00e9);
    wr(tdm_pkg::OFS_ADDR_CFG, 16'h0601);
    rd(tdm_pkg::OFS_ADDR_CFG, 16'hffff, 16'h0601);
    rd(8'h36, 16'hffff, 16'h0000);
    done("registers");
    // Device sends to the peer in every slot, one slot enabled at a time
    for (int s = 0; s < 8; s++) begin
      w = 16'($urandom);
      wr(tdm_pkg::OFS_SLOT_EN, 16'h0001 << s);
      repeat (2 * frame_n) @(negedge ref_clk);
      peer_q.push_back({3'(s), w});
      wr(tdm_pkg::OFS_TRANSMIT, w);
      wait_peer();
    end
    chk("device irq on own slots", 32'h0000_0000, 32'(irq_count));
    done("device to peer");
    // Peer sends in slot 5: first to a foreign address, then to the device
    tx_slot = 3'h5;
    tx_addr = 8'h80;
    send(16'($urandom));
    repeat (2 * frame_n) @(negedge ref_clk);
    chk("irq on foreign address", 32'h0000_0000, 32'(irq_count));
    tx_addr = 8'h81;
    w = 16'($urandom);
    send(w);
    wait_irq(1);
    rd(tdm_pkg::OFS_RECEIVE, 16'hffff, w);
    rd(tdm_pkg::OFS_HISTORY, 16'h07ff, 16'h0681);
    done("peer to device");
    // Device makes the bus clock and hears its own slot 7 word
    wr(tdm_pkg::OFS_ADDR_CFG, 16'h0603);
    wr(tdm_pkg::OFS_CONTROL, 16'h00f1);
    frame_n = 512;
    repeat (2 * frame_n) @(negedge ref_clk);
    rd(tdm_pkg::OFS_CONTROL, 16'h00ff, 16'h00f1);
    w = 16'($urandom);
    peer_q.push_back({3'h7, w});
    wr(tdm_pkg::OFS_TRANSMIT, w);
    wait_peer();
    wait_irq(2);
    rd(tdm_pkg::OFS_RECEIVE, 16'hffff, w);
    rd(tdm_pkg::OFS_HISTORY, 16'h07ff, 16'h0006);
    done("device clock source");
    repeat (4) @(negedge ref_clk);
    end_sim();
  end
endmodule
